// ---- fcis_map.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the friction and inertia block.
// Assumes: Avalon-MM word addressing by byte address, 32-bit data.
// Notes: Definitions only.
// What this block does
// - Offset compensation added outside torque control.
// - Forward command adds forward friction value.
// - Negative command adds reverse friction value.
// - Total is offset plus direction friction value.
// - Direction latch cleared at power-up, de-energising.
// - Torque control forces both compensations zero.
// - Velocity servo-off: offset applied, friction zero.
// - Position servo-on: hold until first command.
// - Select OFF first ratio, ON second.
// - Switching works in all modes 0-6.
`ifndef FCIS_MAP_SVH
`define FCIS_MAP_SVH
`define FCIS_TW 16
`define FCIS_OFS_MODE 8'h00
`define FCIS_OFS_OFFSET 8'h04
`define FCIS_OFS_FWD 8'h08
`define FCIS_OFS_REV 8'h0C
`define FCIS_OFS_INERTIA1 8'h10
`define FCIS_OFS_INERTIA2 8'h14
`define FCIS_OFS_FUNCEXP 8'h18
`define FCIS_OFS_STATUS 8'h1C
`define FCIS_OFS_COMP 8'h20
`define FCIS_FUNCEXP_INERTIA_BIT 3
`define FCIS_RST_MODE 3'h0
`define FCIS_RST_WORD 16'h0000
`define FCIS_MODE_POS 3'h0
`define FCIS_MODE_VEL 3'h1
`define FCIS_MODE_TRQ 3'h2
`define FCIS_MODE_POSVEL 3'h3
`define FCIS_MODE_POSTRQ 3'h4
`define FCIS_MODE_VELTRQ 3'h5
`define FCIS_MODE_FULL 3'h6
`define FCIS_CLK_NS 100
`define FCIS_CTRL_PERIOD_NS 1000
`endif

// ---- fcis_pkg.sv ----
// Purpose: Types shared by the friction and inertia block.
// Assumes: fcis_map.svh supplies the torque width.
// Notes: Types only.
`include "fcis_map.svh"
package fcis_pkg;
	// Latched direction of the most recent nonzero positional command.
	typedef enum logic [1:0] {DIR_NONE, DIR_FWD, DIR_REV} fcis_dir_t;
	// Loop that is actually running after hybrid modes are resolved.
	typedef enum logic [1:0] {LOOP_POS, LOOP_VEL, LOOP_TRQ} fcis_loop_t;
	// Positional command word from the host side.
	typedef struct packed {
		logic valid;
		logic signed [`FCIS_TW-1:0] value;
	} fcis_poscmd_t;
	// Pair of compensation terms.
	typedef struct packed {
		logic signed [`FCIS_TW-1:0] offset;
		logic signed [`FCIS_TW-1:0] dyn;
	} fcis_comp_t;
endpackage : fcis_pkg

// ---- fcis_core.sv ----
// Purpose: Adds offset and dynamic friction compensation to the torque command and picks the inertia ratio.
// Assumes: Positional commands and servo state come from logic on clk_sys; the select pins are asynchronous.
// Notes: Registers sit on an Avalon-MM slave with one wait cycle per access.
// Notes: Compensation terms and both outputs move only on the control tick.
// Notes: The servo-on input and the positional command are same-clock signals and are not synchronised.
// Notes: Inertia switching needs bit 3 of the function expansion word.
`timescale 1ns/10ps
`default_nettype none
`include "fcis_map.svh"
module fcis_core #(
	parameter int CTRL_DIV = `FCIS_CTRL_PERIOD_NS / `FCIS_CLK_NS
) (
	input wire logic clk_sys, // System clock, 10 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic [7:0] avs_address, // Byte address.
	input wire logic avs_read, // Read request.
	input wire logic avs_write, // Write request.
	input wire logic [31:0] avs_writedata, // Write data.
	output logic [31:0] avs_readdata, // Read data.
	output logic avs_waitrequest, // Stall while high.
	input wire fcis_pkg::fcis_poscmd_t posCmd, // Positional command, one cycle valid.
	input wire logic servoOn, // Motor energised.
	input wire logic inertiaSelPin, // Inertia-select pin, high means ON.
	input wire logic modeSelPin, // Hybrid mode select pin, high picks the second loop.
	input wire logic signed [`FCIS_TW-1:0] torqueCmdIn, // Torque command from the loop.
	output logic signed [`FCIS_TW-1:0] torqueCmdOut, // Compensated torque command.
	output logic [`FCIS_TW-1:0] inertiaRatio, // Inertia ratio in use.
	output logic ctrlTick // One-cycle pulse per control cycle.
);
	// One extra count of headroom keeps the wrap compare inside the divider width.
	localparam int DW = $clog2(CTRL_DIV + 1); // Divider width.

	// Saturating signed add used for the compensation sum and the output.
	// Large friction values on top of a large torque command can leave the 16-bit range.
	// Clamping to the nearest limit keeps the sign right, where a plain wrap would reverse it.
	// The sum is formed one bit wider so that overflow shows as a mismatch of the top two bits.
	function automatic logic signed [`FCIS_TW-1:0] satAdd(input logic signed [`FCIS_TW-1:0] a,
		input logic signed [`FCIS_TW-1:0] b);
		logic signed [`FCIS_TW:0] s;
		s = {a[`FCIS_TW-1], a} + {b[`FCIS_TW-1], b};
		if (s[`FCIS_TW] != s[`FCIS_TW-1]) begin
			satAdd = s[`FCIS_TW] ? {1'b1, {(`FCIS_TW-1){1'b0}}} : {1'b0, {(`FCIS_TW-1){1'b1}}};
		end else begin
			satAdd = s[`FCIS_TW-1:0];
		end
	endfunction : satAdd

	// Reset release synchroniser.
	// Assertion reaches every register at once; release passes two flops.
	// No register can then leave reset close to a clock edge.
	logic rstMeta_q;
	logic rstSync_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	// Pin synchronisers; only the second stage is read by logic.
	// Bit 0 carries the inertia select pin and bit 1 the hybrid mode select pin.
	// The host moves both pins with no regard to this clock.
	logic [1:0] pinMeta_q;
	logic [1:0] pinSync_q;
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			pinMeta_q <= 2'h0;
			pinSync_q <= 2'h0;
		end else begin
			pinMeta_q <= {modeSelPin, inertiaSelPin};
			pinSync_q <= pinMeta_q;
		end
	end

	// Control-cycle divider.
	// The count starts at zero after reset and wraps after CTRL_DIV cycles.
	// The tick stands in the last count of every period.
	// The tick is decoded from the count, so it is a one-cycle pulse.
	logic [DW-1:0] div_q;
	logic [DW-1:0] div_d;
	always_comb begin
		div_d = div_q + DW'(1);
		if (div_q == DW'(CTRL_DIV - 1)) begin
			div_d = '0;
		end
	end
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end
	assign ctrlTick = (div_q == DW'(CTRL_DIV - 1));

	// Software registers.
	// Each value sits in the low bits of its word and the upper bits read as zero.
	// Signed values read back without sign extension.
	logic [2:0] mode_q, mode_d; // Control mode setting.
	logic signed [`FCIS_TW-1:0] offset_q, offset_d; // Offset load compensation value.
	logic signed [`FCIS_TW-1:0] fwd_q, fwd_d; // Forward friction value.
	logic signed [`FCIS_TW-1:0] rev_q, rev_d; // Reverse friction value.
	logic [`FCIS_TW-1:0] inert1_q, inert1_d; // First inertia ratio.
	logic [`FCIS_TW-1:0] inert2_q, inert2_d; // Second inertia ratio.
	logic [`FCIS_TW-1:0] funcExp_q, funcExp_d; // Function expansion setting.
	logic ack_q, ack_d; // High in the cycle the access completes.
	logic [31:0] rdata_q, rdata_d; // Read data register.

	// Compensation state.
	// The direction latch and the seen flag follow every clock; the terms follow the tick.
	fcis_pkg::fcis_dir_t dir_q, dir_d; // Latched command direction.
	logic seen_q, seen_d; // A nonzero positional command arrived since servo-on.
	fcis_pkg::fcis_comp_t comp_q, comp_d; // Applied compensation terms.
	logic signed [`FCIS_TW-1:0] torque_q, torque_d; // Output torque.
	logic [`FCIS_TW-1:0] ratio_q, ratio_d; // Output inertia ratio.
	logic signed [`FCIS_TW-1:0] compSum; // Offset plus dynamic term.
	fcis_pkg::fcis_loop_t loop; // Loop currently running.

	// Sum of the two terms now in force; software can read it back.
	assign compSum = satAdd(comp_q.offset, comp_q.dyn);

	// Bus slave: one wait cycle, read data captured as the wait ends.
	// The first cycle of every access stalls and sets ack; the second completes it.
	// Read data are loaded into a register at the end of the stall cycle, so they stand
	// in the completion cycle and until the stall cycle of the next read ends.
	// Unmapped addresses read as zero and ignore writes; the two read-only words also ignore writes.
	always_comb begin
		mode_d = mode_q;
		offset_d = offset_q;
		fwd_d = fwd_q;
		rev_d = rev_q;
		inert1_d = inert1_q;
		inert2_d = inert2_q;
		funcExp_d = funcExp_q;
		rdata_d = rdata_q;
		ack_d = (avs_read || avs_write) && !ack_q;
		// Read decode runs in the stall cycle.
		if (ack_d && avs_read) begin
			rdata_d = 32'h0000_0000;
			if (avs_address == `FCIS_OFS_MODE) begin
				rdata_d = {29'h0, mode_q};
			end else if (avs_address == `FCIS_OFS_OFFSET) begin
				rdata_d = {16'h0, offset_q};
			end else if (avs_address == `FCIS_OFS_FWD) begin
				rdata_d = {16'h0, fwd_q};
			end else if (avs_address == `FCIS_OFS_REV) begin
				rdata_d = {16'h0, rev_q};
			end else if (avs_address == `FCIS_OFS_INERTIA1) begin
				rdata_d = {16'h0, inert1_q};
			end else if (avs_address == `FCIS_OFS_INERTIA2) begin
				rdata_d = {16'h0, inert2_q};
			end else if (avs_address == `FCIS_OFS_FUNCEXP) begin
				rdata_d = {16'h0, funcExp_q};
			end else if (avs_address == `FCIS_OFS_STATUS) begin
				rdata_d = {26'h0, pinSync_q, seen_q, servoOn, dir_q};
			end else if (avs_address == `FCIS_OFS_COMP) begin
				rdata_d = {16'h0, compSum};
			end
		end
		// Writes land on the edge where waitrequest is low.
		if (ack_q && avs_write) begin
			if (avs_address == `FCIS_OFS_MODE) begin
				mode_d = avs_writedata[2:0];
			end else if (avs_address == `FCIS_OFS_OFFSET) begin
				offset_d = avs_writedata[15:0];
			end else if (avs_address == `FCIS_OFS_FWD) begin
				fwd_d = avs_writedata[15:0];
			end else if (avs_address == `FCIS_OFS_REV) begin
				rev_d = avs_writedata[15:0];
			end else if (avs_address == `FCIS_OFS_INERTIA1) begin
				inert1_d = avs_writedata[15:0];
			end else if (avs_address == `FCIS_OFS_INERTIA2) begin
				inert2_d = avs_writedata[15:0];
			end else if (avs_address == `FCIS_OFS_FUNCEXP) begin
				funcExp_d = avs_writedata[15:0];
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			mode_q <= `FCIS_RST_MODE;
			offset_q <= `FCIS_RST_WORD;
			fwd_q <= `FCIS_RST_WORD;
			rev_q <= `FCIS_RST_WORD;
			inert1_q <= `FCIS_RST_WORD;
			inert2_q <= `FCIS_RST_WORD;
			funcExp_q <= `FCIS_RST_WORD;
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			mode_q <= mode_d;
			offset_q <= offset_d;
			fwd_q <= fwd_d;
			rev_q <= rev_d;
			inert1_q <= inert1_d;
			inert2_q <= inert2_d;
			funcExp_q <= funcExp_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end
	// Waitrequest drops in the second cycle of an access and stays low while idle.
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign avs_readdata = rdata_q;

	// Resolve hybrid modes with the mode select pin.
	// A hybrid mode runs its first named loop while the pin is low.
	// Codes above six fall back to the position loop.
	always_comb begin
		case (mode_q)
			`FCIS_MODE_POS, `FCIS_MODE_FULL: loop = fcis_pkg::LOOP_POS;
			`FCIS_MODE_VEL: loop = fcis_pkg::LOOP_VEL;
			`FCIS_MODE_TRQ: loop = fcis_pkg::LOOP_TRQ;
			`FCIS_MODE_POSVEL: loop = pinSync_q[1] ? fcis_pkg::LOOP_VEL : fcis_pkg::LOOP_POS;
			`FCIS_MODE_POSTRQ: loop = pinSync_q[1] ? fcis_pkg::LOOP_TRQ : fcis_pkg::LOOP_POS;
			`FCIS_MODE_VELTRQ: loop = pinSync_q[1] ? fcis_pkg::LOOP_TRQ : fcis_pkg::LOOP_VEL;
			default: loop = fcis_pkg::LOOP_POS;
		endcase
	end

	// Direction latch and compensation terms.
	// A zero command keeps the old direction, and servo-off clears it together with the seen flag.
	// On the tick the terms are chosen from the loop that runs; the torque output takes the terms
	// registered on the previous tick, so a new term reaches the output one control cycle later.
	// The inertia ratio is picked on the same tick in every mode.
	// A hybrid mode switch takes effect on the next tick.
	always_comb begin
		dir_d = dir_q;
		seen_d = seen_q;
		comp_d = comp_q;
		torque_d = torque_q;
		ratio_d = ratio_q;
		// Direction follows nonzero commands only.
		if (!servoOn) begin
			dir_d = fcis_pkg::DIR_NONE;
			seen_d = 1'b0;
		end else if (posCmd.valid && posCmd.value != '0) begin
			dir_d = posCmd.value[`FCIS_TW-1] ? fcis_pkg::DIR_REV : fcis_pkg::DIR_FWD;
			seen_d = 1'b1;
		end
		// Terms, torque and ratio move only on the control tick.
		if (ctrlTick) begin
			case (loop)
				// Torque loop: nothing is added.
				fcis_pkg::LOOP_TRQ: begin
					comp_d = '0;
				end
				// Velocity loop: offset always, direction term only while energised.
				fcis_pkg::LOOP_VEL: begin
					comp_d.offset = offset_q;
					comp_d.dyn = '0;
					if (servoOn && dir_q == fcis_pkg::DIR_FWD) begin
						comp_d.dyn = fwd_q;
					end else if (servoOn && dir_q == fcis_pkg::DIR_REV) begin
						comp_d.dyn = rev_q;
					end
				end
				default: begin
					// Servo-on position loop keeps old terms until a command arrives.
					if (!servoOn || seen_q) begin
						comp_d.offset = offset_q;
						comp_d.dyn = '0;
						if (dir_q == fcis_pkg::DIR_FWD) begin
							comp_d.dyn = fwd_q;
						end else if (dir_q == fcis_pkg::DIR_REV) begin
							comp_d.dyn = rev_q;
						end
					end
				end
			endcase
			torque_d = satAdd(torqueCmdIn, compSum);
			// Ratio choice is mode independent.
			// The second ratio needs the enable bit and the synchronised pin both high.
			ratio_d = inert1_q;
			if (funcExp_q[`FCIS_FUNCEXP_INERTIA_BIT] && pinSync_q[0]) begin
				ratio_d = inert2_q;
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			dir_q <= fcis_pkg::DIR_NONE;
			seen_q <= 1'b0;
			comp_q <= '0;
			torque_q <= '0;
			ratio_q <= '0;
		end else begin
			dir_q <= dir_d;
			seen_q <= seen_d;
			comp_q <= comp_d;
			torque_q <= torque_d;
			ratio_q <= ratio_d;
		end
	end
	// Outputs come straight from flip-flops.
	assign torqueCmdOut = torque_q;
	assign inertiaRatio = ratio_q;
endmodule : fcis_core
`default_nettype wire

// ---- fcis_core_monitor.sv ----
// Purpose: Port assertions for fcis_core.
// Assumes: Bound from the testbench top file.
// Notes: One clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "fcis_map.svh"
module fcis_core_monitor #(
	parameter int CTRL_DIV = 10
) (
	input wire logic clk_sys, // Clock.
	input wire logic rst_n, // Reset.
	input wire logic [7:0] avs_address, // Address.
	input wire logic avs_read, // Read.
	input wire logic avs_write, // Write.
	input wire logic [31:0] avs_writedata, // Write data.
	input wire logic [31:0] avs_readdata, // Read data.
	input wire logic avs_waitrequest, // Stall.
	input wire fcis_pkg::fcis_poscmd_t posCmd, // Command.
	input wire logic servoOn, // Energised.
	input wire logic inertiaSelPin, // Select.
	input wire logic modeSelPin, // Hybrid pick.
	input wire logic signed [`FCIS_TW-1:0] torqueCmdIn, // Torque in.
	input wire logic signed [`FCIS_TW-1:0] torqueCmdOut, // Torque out.
	input wire logic [`FCIS_TW-1:0] inertiaRatio, // Ratio.
	input wire logic ctrlTick // Tick.
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [7:0] gap_q; // Cycles since the last tick, less one.
	logic seen_q; // A tick has been seen.
	logic isTrq_q; // Torque mode was written.
	logic [1:0] trqTicks_q; // Ticks spent in torque mode.
	// Tracks the tick spacing and how long torque mode has run.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gap_q <= 8'h00;
			seen_q <= 1'b0;
			isTrq_q <= 1'b0;
			trqTicks_q <= 2'h0;
		end else begin
			gap_q <= ctrlTick ? 8'h00 : gap_q + 8'h01;
			seen_q <= seen_q | ctrlTick;
			if (avs_write && !avs_waitrequest && avs_address == `FCIS_OFS_MODE) begin
				isTrq_q <= avs_writedata[2:0] == `FCIS_MODE_TRQ;
				trqTicks_q <= 2'h0;
			end else if (ctrlTick && isTrq_q && trqTicks_q != 2'h3) begin
				trqTicks_q <= trqTicks_q + 2'h1;
			end
		end
	end
	// A fresh request stalls once, then completes.
	sequence sAccess;
		(avs_read || avs_write) && avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	chk_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> sAccess)
		else $error("access did not take one wait cycle");
	chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait request held too long");
	chk_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait request while idle");
	chk_rdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
		else $error("read data moved without a read");
	chk_tick_period: assert property (ctrlTick && seen_q |-> gap_q == CTRL_DIV - 1)
		else $error("control tick spacing wrong");
	chk_out_hold: assert property (!$past(ctrlTick) |-> $stable(torqueCmdOut))
		else $error("torque output moved between ticks");
	chk_ratio_hold: assert property (!$past(ctrlTick) |-> $stable(inertiaRatio))
		else $error("ratio moved between ticks");
	chk_trq_pass: assert property (ctrlTick && trqTicks_q == 2'h3 |=> torqueCmdOut == $past(torqueCmdIn))
		else $error("torque mode output carries compensation");
endmodule : fcis_core_monitor
`default_nettype wire

// ---- fcis_host_model.sv ----
// Purpose: Host side model issuing positional commands and the select pin.
// Assumes: The bench raises cmdReq for one cycle per command.
// Notes: The select pin only moves between commands.
`timescale 1ns/10ps
`default_nettype none
module fcis_host_model (
	input wire logic clk_sys, // Clock.
	input wire logic cmdReq, // Issue one command.
	input wire logic [15:0] cmdVal, // Command value.
	input wire logic selReq, // Wanted select level.
	output fcis_pkg::fcis_poscmd_t posCmd, // Command to the block.
	output logic inertiaSelPin // Select pin, high is ON.
);
	fcis_pkg::fcis_poscmd_t cmd_q = '0; // Command register, known before the first edge.
	logic sel_q = 1'b0; // Select level register, known before the first edge.
	// Pulses a command; idle value toggles so stale data never looks valid.
	always @(posedge clk_sys) begin
		cmd_q.valid <= cmdReq;
		cmd_q.value <= cmdReq ? cmdVal : ~cmd_q.value;
		if (!cmdReq && !cmd_q.valid) begin
			sel_q <= selReq;
		end
	end
	assign posCmd = cmd_q;
	assign inertiaSelPin = sel_q;
endmodule : fcis_host_model
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for fcis_core.
// Assumes: CTRL_DIV is shortened to 4.
// Notes: Row table first, then hand cases.
`timescale 1ns/10ps
`default_nettype none
`include "fcis_map.svh"
module testbench;
	localparam int CTRL_DIV = 4; // Short control cycle.
	logic clk_sys = 1'b0; // Clock.
	logic rst_n = 1'b0; // Reset.
	logic [7:0] avs_address = 8'h00; // Bus address.
	logic avs_read = 1'b0; // Bus read.
	logic avs_write = 1'b0; // Bus write.
	logic [31:0] avs_writedata = 32'h0; // Bus data.
	logic [31:0] avs_readdata; // Bus read data.
	logic avs_waitrequest; // Bus stall.
	fcis_pkg::fcis_poscmd_t posCmd; // Model command.
	logic inertiaSelPin; // Model select.
	logic servoOn = 1'b0; // Energised.
	logic cmdReq = 1'b0; // Model trigger.
	logic selReq = 1'b0; // Model select request.
	logic modeSel = 1'b0; // Hybrid mode select pin.
	logic [15:0] cmdVal = 16'h0; // Command value.
	logic signed [15:0] trqIn = 16'sh0100; // Torque in.
	logic signed [15:0] torqueCmdOut; // Torque out.
	logic [15:0] inertiaRatio; // Ratio.
	logic ctrlTick; // Tick.
	logic [31:0] rd; // Last read word.
	int errors = 0;
	int samples_checked = 0;
	// Mode, servo, command and expected compensation.
	typedef struct packed {logic [2:0] m; logic s; logic [15:0] c; logic [15:0] e;} fcis_row_t;
	localparam fcis_row_t ROWS [7] = '{'{3'h0, 1'b1, 16'h0005, 16'h0013}, '{3'h0, 1'b1, 16'hFFFB, 16'h0015},
		'{3'h0, 1'b1, 16'h0000, 16'h0015}, '{3'h1, 1'b0, 16'h0000, 16'h0010}, '{3'h2, 1'b1, 16'h0005, 16'h0000},
		'{3'h3, 1'b1, 16'hFFFB, 16'h0015}, '{3'h6, 1'b1, 16'h0005, 16'h0013}};
	fcis_core #(.CTRL_DIV(CTRL_DIV)) fcis_core_i (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .posCmd(posCmd), .servoOn(servoOn), .inertiaSelPin(inertiaSelPin),
		.modeSelPin(modeSel), .torqueCmdIn(trqIn), .torqueCmdOut(torqueCmdOut), .inertiaRatio(inertiaRatio),
		.ctrlTick(ctrlTick));
	fcis_host_model fcis_host_model_i (.clk_sys(clk_sys), .cmdReq(cmdReq), .cmdVal(cmdVal), .selReq(selReq),
		.posCmd(posCmd), .inertiaSelPin(inertiaSelPin));
	// Free-running clock.
	always #50 clk_sys = ~clk_sys;
	// Counts and reports one comparison.
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	// One bus access held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	// Waits for k control ticks.
	task automatic ticks(input int k);
		repeat (k) begin
			do @(posedge clk_sys); while (ctrlTick !== 1'b1);
		end
	endtask : ticks
	// Asks the model for one command.
	task automatic cmd(input logic [15:0] v);
		cmdVal <= v;
		cmdReq <= 1'b1;
		@(posedge clk_sys);
		cmdReq <= 1'b0;
		@(posedge clk_sys);
	endtask : cmd
	// Prints the verdict and stops.
	task automatic final_report;
		if (errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	// Cuts a hang short.
	initial begin
		#1000000;
		errors++;
		final_report();
	end
	// Main sequence.
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		bus(1'b1, `FCIS_OFS_OFFSET, 32'h10);
		bus(1'b1, `FCIS_OFS_FWD, 32'h3);
		bus(1'b1, `FCIS_OFS_REV, 32'h5);
		foreach (ROWS[i]) begin
			bus(1'b1, `FCIS_OFS_MODE, {29'h0, ROWS[i].m});
			servoOn <= ROWS[i].s;
			trqIn <= 16'sh0100 + 16'(i);
			cmd(ROWS[i].c);
			ticks(4);
			check("torque", {16'h0, torqueCmdOut}, {16'h0, 16'h0100 + 16'(i) + ROWS[i].e});
			bus(1'b0, `FCIS_OFS_COMP, 32'h0);
			check("comp", rd, {16'h0, ROWS[i].e});
		end
		// Servo off clears the direction, then servo on holds until a command.
		servoOn <= 1'b0;
		ticks(2);
		bus(1'b0, `FCIS_OFS_STATUS, 32'h0);
		check("dir", {30'h0, rd[1:0]}, 32'h0);
		servoOn <= 1'b1;
		bus(1'b1, `FCIS_OFS_OFFSET, 32'h20);
		bus(1'b1, `FCIS_OFS_MODE, 32'h0);
		ticks(3);
		bus(1'b0, `FCIS_OFS_COMP, 32'h0);
		check("held", rd, 32'h10);
		cmd(16'hFFFB);
		ticks(2);
		bus(1'b0, `FCIS_OFS_COMP, 32'h0);
		check("loaded", rd, 32'h25);
		// Hybrid modes: pin high picks torque in mode 4, pin low picks velocity in mode 5.
		modeSel <= 1'b1;
		bus(1'b1, `FCIS_OFS_MODE, 32'h4);
		ticks(3);
		bus(1'b0, `FCIS_OFS_COMP, 32'h0);
		check("hybrid trq", rd, 32'h0);
		modeSel <= 1'b0;
		bus(1'b1, `FCIS_OFS_MODE, 32'h5);
		ticks(3);
		bus(1'b0, `FCIS_OFS_COMP, 32'h0);
		check("hybrid vel", rd, 32'h25);
		bus(1'b0, 8'h40, 32'h0);
		check("unmapped", rd, 32'h0);
		// Inertia select in every mode.
		bus(1'b1, `FCIS_OFS_INERTIA1, 32'h64);
		bus(1'b1, `FCIS_OFS_INERTIA2, 32'hC8);
		// Only bit 3 is set; the tuning, adaptive filter and observer bits stay zero.
		bus(1'b1, `FCIS_OFS_FUNCEXP, 32'h8);
		for (int m = 0; m < 7; m++) begin
			bus(1'b1, `FCIS_OFS_MODE, 32'(m));
			selReq <= 1'b0;
			ticks(3);
			check("ratio1", {16'h0, inertiaRatio}, 32'h64);
			selReq <= 1'b1;
			ticks(3);
			check("ratio2", {16'h0, inertiaRatio}, 32'hC8);
		end
		bus(1'b1, `FCIS_OFS_FUNCEXP, 32'h0);
		ticks(3);
		check("disabled", {16'h0, inertiaRatio}, 32'h64);
		// Reset in mid-run returns outputs to zero.
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check("rst out", {16'h0, torqueCmdOut}, 32'h0);
		check("rst ratio", {16'h0, inertiaRatio}, 32'h0);
		// Release again and confirm the direction starts cleared.
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		bus(1'b0, `FCIS_OFS_STATUS, 32'h0);
		check("rst dir", {30'h0, rd[1:0]}, 32'h0);
		final_report();
	end
endmodule : testbench
bind fcis_core fcis_core_monitor #(.CTRL_DIV(CTRL_DIV)) fcis_core_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .posCmd(posCmd), .servoOn(servoOn),
	.inertiaSelPin(inertiaSelPin), .modeSelPin(modeSelPin), .torqueCmdIn(torqueCmdIn),
	.torqueCmdOut(torqueCmdOut), .inertiaRatio(inertiaRatio), .ctrlTick(ctrlTick));
`default_nettype wire
